// File: core/rldr_pkg.sv
// constants and types shared by the rx lane diagnostic register bank
package rldr_pkg;

  // management register offsets inside device addresses 4 and 5
  localparam logic [15:0] TALLY0_ADDR = 16'h8010;
  localparam logic [15:0] TALLY1_ADDR = 16'h8011;
  localparam logic [15:0] TALLY2_ADDR = 16'h8012;
  localparam logic [15:0] TALLY3_ADDR = 16'h8013;
  localparam logic [15:0] SYNC_STATES_ADDR = 16'h8014;
  localparam logic [15:0] DESKEW_ADDR = 16'h8015;
  localparam logic [15:0] ALL_SYNC_ADDR = 16'h8016;
  localparam logic [15:0] BITREV_ADDR = 16'h8017;
  localparam logic [15:0] LOOPSEL_ADDR = 16'h8018;

  // reset values and the counter maximum
  localparam logic [15:0] TALLY_RESET = 16'hFFFD;
  localparam logic [15:0] TALLY_MAX = 16'hFFFF;
  localparam logic [15:0] BITREV_RESET = 16'h0005;
  localparam logic [15:0] LOOPSEL_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // field positions
  localparam int BR_XGMII_RX_BIT = 3;
  localparam int BR_XAUI_RX_BIT = 2;
  localparam int BR_XGMII_TX_BIT = 1;
  localparam int BR_XAUI_TX_BIT = 0;
  localparam int LB_SERIAL_BIT = 1;
  localparam int LB_HOST_BIT = 0;
  localparam int SYNC_STATES_LSB = 0;
  localparam int SYNC_STATES_MSB = 11;
  localparam int ALIGN_STATE_LSB = 12;
  localparam int COLLISION_BIT = 0;
  localparam int ALL_SYNC_BIT = 11;

  // management frame layout
  localparam logic [4:0] DEVAD_A = 5'h04;
  localparam logic [4:0] DEVAD_B = 5'h05;
  localparam logic [1:0] FRAME_START = 2'h0;
  localparam logic [1:0] OP_ADDRESS = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [5:0] HEADER_LAST = 6'h0D;
  localparam logic [5:0] DATA_LAST = 6'h0F;

  // management frame engine states
  typedef enum logic [1:0] {
    MS_PREAMBLE,
    MS_HEADER,
    MS_TURN,
    MS_DATA
  } rldr_mframe_state_type;

endpackage

// File: core/rldr_bitrev.sv
// per-lane bit order reversal, purely combinational
module rldr_bitrev import rldr_pkg::*; #(
  parameter int LANE_W = 8,
  parameter int LANES = 4
) (
  // control
  input wire logic en,
  // data
  input wire logic [LANE_W*LANES-1:0] din,
  output logic [LANE_W*LANES-1:0] dout
);

  // mirror each lane on its own, lanes keep their place
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      for (int b = 0; b < LANE_W; b++) begin
        dout[l*LANE_W+b] = en ? din[l*LANE_W+LANE_W-1-b] : din[l*LANE_W+b];
      end
    end
  end

endmodule // rldr_bitrev

// File: core/rldr_tally.sv
// one saturating, clear-on-read invalid code group counter
module rldr_tally import rldr_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // events
  input wire logic code_err,
  input wire logic align_ok,
  input wire logic rd_clr,
  // state
  output logic [15:0] count
);

  logic [15:0] next_count; // value after this edge
  logic bump; // an error that may be counted

  // count only while aligned, saturate, restart from a read
  always_comb begin
    bump = code_err && align_ok;
    if (rd_clr) begin
      // the error in the clearing cycle is kept
      next_count = bump ? 16'h0001 : 16'h0000;
    end else if (bump && count != TALLY_MAX) begin
      next_count = count + 16'h0001;
    end else begin
      next_count = count;
    end
  end

  // register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= TALLY_RESET;
    end else begin
      count <= next_count;
    end
  end

  property p_tally_inc;
    @(posedge core_clk) disable iff (!resetn)
    code_err && align_ok && !rd_clr && count != TALLY_MAX
      |=> count == $past(count) + 16'h0001;
  endproperty
  a_tally_inc: assert property (p_tally_inc)
    else $error("tally did not advance on error");

  property p_tally_hold;
    @(posedge core_clk) disable iff (!resetn)
    !align_ok && !rd_clr |=> $stable(count);
  endproperty
  a_tally_hold: assert property (p_tally_hold)
    else $error("tally moved while lanes not aligned");

  property p_tally_sat;
    @(posedge core_clk) disable iff (!resetn)
    count == TALLY_MAX && !rd_clr |=> count == TALLY_MAX;
  endproperty
  a_tally_sat: assert property (p_tally_sat)
    else $error("tally wrapped past maximum");

  property p_tally_clr;
    @(posedge core_clk) disable iff (!resetn)
    rd_clr |=> count == {15'h0000, $past(code_err && align_ok)};
  endproperty
  a_tally_clr: assert property (p_tally_clr)
    else $error("tally read clear lost or kept counts");

  c_tally_sat: cover property (@(posedge core_clk) disable iff (!resetn)
    count == TALLY_MAX && code_err && align_ok);

endmodule // rldr_tally

// File: core/rldr_regs.sv
// rx lane diagnostic, bit order and loopback registers behind the mdio port
// How it works
// - per-lane 16-bit counter counts undecodable groups
// - counting only while all lanes aligned
// - counter saturates at maximum, never wraps
// - reading a counter returns then clears it
// - per-lane sync state, 3 bits each
// - alignment state in bits 15 to 12
// - fifo collision bit latched high until read
// - all-lanes sync bit latched low until read
// - bit 3 reverses rx data toward host
// - bit 2 reverses data from deserializers
// - bit 1 reverses host transmit data
// - bit 0 reverses serializer data; reset 0x0005
// - bit 1 loops rx xgmii into tx
// - bit 0 loops 40-bit tx into rx
module rldr_regs import rldr_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // management serial port, sampled in the core clock
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic [4:0] port_addr,
  // receive status from the lane logic
  input wire logic [3:0] code_err,
  input wire logic align_ok,
  input wire logic [11:0] lane_sync_state,
  input wire logic [3:0] deskew_state,
  input wire logic deskew_collision,
  input wire logic all_lanes_sync,
  input wire logic ctrl0_bit14,
  // deserializer data of channels a and b, 4 lanes of 10 bits
  input wire logic [39:0] rxa_raw,
  input wire logic [39:0] rxb_raw,
  output logic [39:0] rxa_ordered,
  output logic [39:0] rxb_ordered,
  // receive xgmii data toward the host
  input wire logic [31:0] rx_path_d,
  input wire logic [3:0] rx_path_c,
  output logic [31:0] host_rx_d,
  output logic [3:0] host_rx_c,
  // transmit xgmii data from the host
  input wire logic [31:0] host_tx_d,
  input wire logic [3:0] host_tx_c,
  output logic [31:0] tx_path_d,
  output logic [3:0] tx_path_c,
  // encoded data toward the serializer
  input wire logic [39:0] tx_enc,
  output logic [39:0] ser_tx
);

  // ---------------- management frame engine ----------------
  rldr_mframe_state_type mstate, next_mstate; // frame phase
  logic mdc_q; // last mdc sample for edge finding
  logic [5:0] bitcnt, next_bitcnt; // bits seen in the phase
  logic [13:0] hdr, next_hdr; // start, op, port, device
  logic [15:0] shreg, next_shreg; // data in or out
  logic [15:0] maddr, next_maddr; // shared register address
  logic [1:0] op, next_op; // op of the frame in flight
  logic sel, next_sel; // frame is for this device
  logic next_mdio_out; // next driven bit
  logic next_mdio_oe_n; // next enable, low drives
  logic mdc_rise; // host data valid here
  logic [13:0] hdr_full; // header with the last bit
  logic is_read; // read op in flight
  logic rd_event; // read data is taken now
  logic wr_event; // write data complete now
  logic [15:0] wr_data; // data of a completed write
  logic [15:0] rd_value; // register contents at maddr

  // register bank state
  logic [15:0] tally [4]; // per-lane counters
  logic [3:0] bitrev, next_bitrev; // reversal enables
  logic [1:0] loopsel, next_loopsel; // loopback enables
  logic collision_flag, next_collision_flag; // latched high
  logic sync_flag, next_sync_flag; // latched low

  assign mdc_rise = mdc && !mdc_q;
  assign hdr_full = {hdr[12:0], mdio_in};
  assign is_read = (op == OP_READ) || (op == OP_READ_INC);
  assign wr_data = {shreg[14:0], mdio_in};
  assign rd_event = mdc_rise && mstate == MS_TURN && bitcnt == 6'h00 &&
    sel && is_read;
  assign wr_event = mdc_rise && mstate == MS_DATA && bitcnt == DATA_LAST &&
    sel && op == OP_WRITE;

  // read mux, unmapped offsets read zero
  always_comb begin
    rd_value = 16'h0000;
    case (maddr)
      TALLY0_ADDR: rd_value = tally[0];
      TALLY1_ADDR: rd_value = tally[1];
      TALLY2_ADDR: rd_value = tally[2];
      TALLY3_ADDR: rd_value = tally[3];
      SYNC_STATES_ADDR: begin
        rd_value[SYNC_STATES_MSB:SYNC_STATES_LSB] = lane_sync_state;
      end
      DESKEW_ADDR: begin
        rd_value[ALIGN_STATE_LSB+:4] = deskew_state;
        rd_value[COLLISION_BIT] = collision_flag;
      end
      ALL_SYNC_ADDR: rd_value[ALL_SYNC_BIT] = sync_flag;
      BITREV_ADDR: rd_value[3:0] = bitrev;
      LOOPSEL_ADDR: rd_value[1:0] = loopsel;
      default: rd_value = 16'h0000;
    endcase
  end

  // frame decoding: preamble, header, turnaround, data
  always_comb begin
    next_mstate = mstate;
    next_bitcnt = bitcnt;
    next_hdr = hdr;
    next_shreg = shreg;
    next_maddr = maddr;
    next_op = op;
    next_sel = sel;
    next_mdio_out = mdio_out;
    next_mdio_oe_n = mdio_oe_n;
    if (mdc_rise) begin
      case (mstate)
        MS_PREAMBLE: begin
          if (mdio_in) begin
            // count ones, saturating at the needed run
            if (bitcnt != PREAMBLE_ONES) begin
              next_bitcnt = bitcnt + 6'h01;
            end
          end else if (bitcnt == PREAMBLE_ONES) begin
            // first start bit taken here
            next_hdr = 14'h0000;
            next_bitcnt = 6'h01;
            next_mstate = MS_HEADER;
          end else begin
            next_bitcnt = 6'h00;
          end
        end
        MS_HEADER: begin
          next_hdr = hdr_full;
          if (bitcnt == HEADER_LAST) begin
            next_op = hdr_full[11:10];
            next_sel = hdr_full[13:12] == FRAME_START &&
              hdr_full[9:5] == port_addr &&
              (hdr_full[4:0] == DEVAD_A || hdr_full[4:0] == DEVAD_B);
            next_bitcnt = 6'h00;
            next_mstate = MS_TURN;
          end else begin
            next_bitcnt = bitcnt + 6'h01;
          end
        end
        MS_TURN: begin
          if (bitcnt == 6'h00) begin
            // second turnaround bit is driven low on reads
            if (sel && is_read) begin
              next_shreg = rd_value;
              next_mdio_out = 1'b0;
              next_mdio_oe_n = 1'b0;
            end
            next_bitcnt = 6'h01;
          end else begin
            if (sel && is_read) begin
              next_mdio_out = shreg[15];
            end
            next_bitcnt = 6'h00;
            next_mstate = MS_DATA;
          end
        end
        MS_DATA: begin
          if (sel && is_read) begin
            next_mdio_out = shreg[14];
            next_shreg = {shreg[14:0], 1'b0};
          end else begin
            next_shreg = wr_data;
          end
          if (bitcnt == DATA_LAST) begin
            // frame done: release the line, settle the address
            next_mdio_out = 1'b1;
            next_mdio_oe_n = 1'b1;
            if (sel && op == OP_ADDRESS) begin
              next_maddr = wr_data;
            end else if (sel && op == OP_READ_INC) begin
              next_maddr = maddr + 16'h0001;
            end
            next_bitcnt = 6'h00;
            next_mstate = MS_PREAMBLE;
          end else begin
            next_bitcnt = bitcnt + 6'h01;
          end
        end
        default: begin
          next_bitcnt = 6'h00;
          next_mstate = MS_PREAMBLE;
        end
      endcase
    end
  end

  // frame engine registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mstate <= MS_PREAMBLE;
      mdc_q <= 1'b0;
      bitcnt <= 6'h00;
      hdr <= 14'h0000;
      shreg <= 16'h0000;
      maddr <= 16'h0000;
      op <= OP_ADDRESS;
      sel <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else begin
      mstate <= next_mstate;
      mdc_q <= mdc;
      bitcnt <= next_bitcnt;
      hdr <= next_hdr;
      shreg <= next_shreg;
      maddr <= next_maddr;
      op <= next_op;
      sel <= next_sel;
      mdio_out <= next_mdio_out;
      mdio_oe_n <= next_mdio_oe_n;
    end
  end

  // ---------------- counters ----------------
  for (genvar g = 0; g < 4; g++) begin : g_tally
    rldr_tally u_tally (
      .core_clk(core_clk),
      .resetn(resetn),
      .code_err(code_err[g]),
      .align_ok(align_ok),
      .rd_clr(rd_event && maddr == TALLY0_ADDR + 16'(g)),
      .count(tally[g])
    );
  end

  // ---------------- control and latched status ----------------
  // a new event beats the clear of the read that sees the old value
  always_comb begin
    next_bitrev = bitrev;
    next_loopsel = loopsel;
    if (wr_event && maddr == BITREV_ADDR) begin
      next_bitrev = wr_data[3:0];
    end
    if (wr_event && maddr == LOOPSEL_ADDR) begin
      next_loopsel = wr_data[1:0];
    end
    next_collision_flag = deskew_collision ||
      (collision_flag && !(rd_event && maddr == DESKEW_ADDR));
    // a read re-arms the flag to the live level, a loss pulls it low
    if (rd_event && maddr == ALL_SYNC_ADDR) begin
      next_sync_flag = all_lanes_sync;
    end else begin
      next_sync_flag = sync_flag && all_lanes_sync;
    end
  end

  // control registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bitrev <= BITREV_RESET[3:0];
      loopsel <= LOOPSEL_RESET[1:0];
      collision_flag <= STATUS_RESET[COLLISION_BIT];
      sync_flag <= STATUS_RESET[ALL_SYNC_BIT];
    end else begin
      bitrev <= next_bitrev;
      loopsel <= next_loopsel;
      collision_flag <= next_collision_flag;
      sync_flag <= next_sync_flag;
    end
  end

  // ---------------- data paths ----------------
  logic lb_serial; // rx xgmii looped into tx
  logic lb_host; // serializer data looped into rx
  logic [39:0] rxa_src, rxb_src; // deserializer or loopback
  logic [39:0] rxa_rev, rxb_rev, ser_rev; // reversed 10-bit lanes
  logic [35:0] xrx_rev, xtx_rev; // reversed bytes, control kept
  logic [39:0] next_rxa_ordered, next_rxb_ordered, next_ser_tx;
  logic [31:0] next_host_rx_d, next_tx_path_d;
  logic [3:0] next_host_rx_c, next_tx_path_c;

  // control bit 14 set disables both loopbacks
  assign lb_serial = loopsel[LB_SERIAL_BIT] && !ctrl0_bit14;
  assign lb_host = loopsel[LB_HOST_BIT] && !ctrl0_bit14;
  // looping the serializer word keeps it aligned with the rx lanes
  assign rxa_src = lb_host ? ser_rev : rxa_raw;
  assign rxb_src = lb_host ? ser_rev : rxb_raw;

  rldr_bitrev #(.LANE_W(10), .LANES(4)) u_rev_rxa (
    .en(bitrev[BR_XAUI_RX_BIT]),
    .din(rxa_src),
    .dout(rxa_rev)
  );

  rldr_bitrev #(.LANE_W(10), .LANES(4)) u_rev_rxb (
    .en(bitrev[BR_XAUI_RX_BIT]),
    .din(rxb_src),
    .dout(rxb_rev)
  );

  rldr_bitrev #(.LANE_W(9), .LANES(4)) u_rev_xrx (
    .en(bitrev[BR_XGMII_RX_BIT]),
    .din({rx_path_c[3], rx_path_d[31:24], rx_path_c[2], rx_path_d[23:16],
      rx_path_c[1], rx_path_d[15:8], rx_path_c[0], rx_path_d[7:0]}),
    .dout(xrx_rev)
  );

  rldr_bitrev #(.LANE_W(9), .LANES(4)) u_rev_xtx (
    .en(bitrev[BR_XGMII_TX_BIT]),
    .din({host_tx_c[3], host_tx_d[31:24], host_tx_c[2], host_tx_d[23:16],
      host_tx_c[1], host_tx_d[15:8], host_tx_c[0], host_tx_d[7:0]}),
    .dout(xtx_rev)
  );

  rldr_bitrev #(.LANE_W(10), .LANES(4)) u_rev_ser (
    .en(bitrev[BR_XAUI_TX_BIT]),
    .din(tx_enc),
    .dout(ser_rev)
  );

  // unpack per-lane words; the control bit sits at the lane top
  always_comb begin
    next_rxa_ordered = rxa_rev;
    next_rxb_ordered = rxb_rev;
    next_ser_tx = ser_rev;
    for (int l = 0; l < 4; l++) begin
      // reversing 9 bits moves the control bit to the lane bottom
      next_host_rx_d[l*8+:8] = bitrev[BR_XGMII_RX_BIT] ?
        xrx_rev[l*9+1+:8] : xrx_rev[l*9+:8];
      next_host_rx_c[l] = bitrev[BR_XGMII_RX_BIT] ?
        xrx_rev[l*9] : xrx_rev[l*9+8];
      next_tx_path_d[l*8+:8] = bitrev[BR_XGMII_TX_BIT] ?
        xtx_rev[l*9+1+:8] : xtx_rev[l*9+:8];
      next_tx_path_c[l] = bitrev[BR_XGMII_TX_BIT] ?
        xtx_rev[l*9] : xtx_rev[l*9+8];
    end
    if (lb_serial) begin
      next_tx_path_d = rx_path_d;
      next_tx_path_c = rx_path_c;
    end
  end

  // data outputs, one register stage each
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxa_ordered <= 40'h00_0000_0000;
      rxb_ordered <= 40'h00_0000_0000;
      host_rx_d <= 32'h0000_0000;
      host_rx_c <= 4'h0;
      tx_path_d <= 32'h0000_0000;
      tx_path_c <= 4'h0;
      ser_tx <= 40'h00_0000_0000;
    end else begin
      rxa_ordered <= next_rxa_ordered;
      rxb_ordered <= next_rxb_ordered;
      host_rx_d <= next_host_rx_d;
      host_rx_c <= next_host_rx_c;
      tx_path_d <= next_tx_path_d;
      tx_path_c <= next_tx_path_c;
      ser_tx <= next_ser_tx;
    end
  end

  // ---------------- checks ----------------
  property p_collision_latch;
    @(posedge core_clk) disable iff (!resetn)
    deskew_collision |=> collision_flag;
  endproperty
  a_collision_latch: assert property (p_collision_latch)
    else $error("collision not latched");

  property p_sync_low;
    @(posedge core_clk) disable iff (!resetn)
    !all_lanes_sync |=> !sync_flag;
  endproperty
  a_sync_low: assert property (p_sync_low)
    else $error("sync loss not latched low");

  property p_rx_plain;
    @(posedge core_clk) disable iff (!resetn)
    !bitrev[BR_XGMII_RX_BIT] |=> host_rx_d == $past(rx_path_d);
  endproperty
  a_rx_plain: assert property (p_rx_plain)
    else $error("rx host data altered without reversal");

  property p_rx_rev;
    @(posedge core_clk) disable iff (!resetn)
    bitrev[BR_XGMII_RX_BIT] |=> host_rx_d[0] == $past(rx_path_d[7]);
  endproperty
  a_rx_rev: assert property (p_rx_rev)
    else $error("rx host byte not reversed");

  property p_serial_loop;
    @(posedge core_clk) disable iff (!resetn)
    loopsel[LB_SERIAL_BIT] && !ctrl0_bit14 |=>
      tx_path_d == $past(rx_path_d) && tx_path_c == $past(rx_path_c);
  endproperty
  a_serial_loop: assert property (p_serial_loop)
    else $error("serial side loopback not applied");

  property p_host_loop;
    @(posedge core_clk) disable iff (!resetn)
    loopsel[LB_HOST_BIT] && !ctrl0_bit14 && !bitrev[BR_XAUI_RX_BIT] |=>
      rxa_ordered == ser_tx;
  endproperty
  a_host_loop: assert property (p_host_loop)
    else $error("host side loopback not applied");

  property p_lb_blocked;
    @(posedge core_clk) disable iff (!resetn)
    ctrl0_bit14 && !bitrev[BR_XAUI_RX_BIT] |=> rxa_ordered == $past(rxa_raw);
  endproperty
  a_lb_blocked: assert property (p_lb_blocked)
    else $error("loopback active while control bit 14 set");

  c_read_frame: cover property (@(posedge core_clk) disable iff (!resetn)
    rd_event);
  c_write_frame: cover property (@(posedge core_clk) disable iff (!resetn)
    wr_event);
  c_collision_read: cover property (@(posedge core_clk)
    disable iff (!resetn) rd_event && maddr == DESKEW_ADDR && collision_flag);

endmodule // rldr_regs

// File: testbench/rldr_mdio_host.sv
// management station model that drives clause 45 frames on the wire
module rldr_mdio_host import rldr_pkg::*; (
  // clock
  input wire logic core_clk,
  // management wire
  input wire logic [4:0] prtad,
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv; // station level, 1 while released (pull-up)
  // pulled-up wire: device wins while its enable is low
  assign mdio_in = mdio_oe_n ? drv : mdio_out;
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
  end
  // one frame; mdc low and high two core cycles each
  task automatic frame(input logic [1:0] op, input logic [4:0] dev,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, FRAME_START, op, prtad, dev, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      // reads let go of the wire from turnaround on
      drv <= (op[1] && i < 18) ? 1'b1 : bits[i];
      mdc <= 1'b0;
      repeat (2) @(posedge core_clk);
      if (i < 16) rd = {rd[14:0], mdio_in};
      mdc <= 1'b1;
      repeat (2) @(posedge core_clk);
    end
    drv <= 1'b1;
  endtask
endmodule // rldr_mdio_host

// File: testbench/rldr_regs_tb.sv
// self-checking bench for the rx lane diagnostic register bank
module rldr_regs_tb import rldr_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, resetn, mdc, mdio_in, mdio_out, mdio_oe_n;
  logic align_ok, deskew_collision, all_lanes_sync, ctrl0_bit14;
  logic [3:0] code_err, deskew_state, rx_path_c, host_rx_c;
  logic [3:0] host_tx_c, tx_path_c, br, ce;
  logic [11:0] lane_sync_state;
  logic [39:0] rxa_raw, rxb_raw, rxa_ordered, rxb_ordered;
  logic [39:0] tx_enc, ser_tx, q_a, q_b, q_e, e, s;
  logic [31:0] rx_path_d, host_rx_d, host_tx_d, tx_path_d;
  logic [35:0] q_r, q_h, h;
  logic [4:0] port_addr;
  logic [15:0] rv;
  logic [1:0] ls;
  logic dchk, q14, ao;
  int failures, comparisons, cycles, tally[4];
  // {bit order, loopback, control bit 14} per data path run
  localparam logic [6:0] CFG [5] = '{7'h28, 7'h52, 7'h7C, 7'h1F, 7'h36};
  rldr_regs dut_u (.core_clk, .resetn, .mdc, .mdio_in, .mdio_out,
    .mdio_oe_n, .port_addr, .code_err, .align_ok, .lane_sync_state,
    .deskew_state, .deskew_collision, .all_lanes_sync, .ctrl0_bit14,
    .rxa_raw, .rxb_raw, .rxa_ordered, .rxb_ordered, .rx_path_d,
    .rx_path_c, .host_rx_d, .host_rx_c, .host_tx_d, .host_tx_c,
    .tx_path_d, .tx_path_c, .tx_enc, .ser_tx);
  rldr_mdio_host host_u (.core_clk, .prtad(port_addr), .mdc, .mdio_in,
    .mdio_out, .mdio_oe_n);
  always #5 core_clk = ~core_clk;
  // expected values: bit order reversed inside each lane
  function automatic logic [39:0] rev10(input logic [39:0] v);
    for (int i = 0; i < 40; i++) rev10[i] = v[(i/10)*10+9-i%10];
  endfunction
  function automatic logic [31:0] rev8(input logic [31:0] v);
    for (int i = 0; i < 32; i++) rev8[i] = v[(i/8)*8+7-i%8];
  endfunction
  task automatic cmp_data(input logic [39:0] got, input logic [39:0] x);
    comparisons++;
    if (got !== x) begin
      failures++;
      $display("Error t=%0t data got %h exp %h", $time, got, x);
    end
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] x);
    comparisons++;
    if (got !== x) begin
      failures++;
      $display("Error t=%0t reg got %h exp %h", $time, got, x);
    end
  endtask
  // address frame then read or write frame
  task automatic acc(input logic [1:0] op, input logic [4:0] dev,
      input logic [15:0] a, input logic [15:0] d, output logic [15:0] v);
    host_u.frame(OP_ADDRESS, dev, a, v);
    host_u.frame(op, dev, d, v);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] x);
    acc(OP_READ, DEVAD_A, a, 16'h0000, rv);
    cmp_reg(rv, x);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // hang guard, about twice the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 45000) begin
      failures++;
      $display("Error t=%0t run did not finish", $time);
      tally_and_finish();
    end
  end
  // fresh random data words every cycle; held at zero through reset so
  // the first registered outputs after release match their past inputs
  always @(posedge core_clk) begin
    if (resetn) begin
      rxa_raw <= 40'({$urandom(), $urandom()});
      rxb_raw <= 40'({$urandom(), $urandom()});
      tx_enc <= 40'({$urandom(), $urandom()});
      {rx_path_c, rx_path_d} <= 36'({$urandom(), $urandom()});
      {host_tx_c, host_tx_d} <= 36'({$urandom(), $urandom()});
    end
  end
  // data paths: outputs are one stage behind the inputs held last cycle
  always @(negedge core_clk) begin
    if (dchk) begin
      e = br[0] ? rev10(q_e) : q_e;
      cmp_data(ser_tx, e);
      s = (ls[0] & ~q14) ? e : q_a;
      cmp_data(rxa_ordered, br[2] ? rev10(s) : s);
      s = (ls[0] & ~q14) ? e : q_b;
      cmp_data(rxb_ordered, br[2] ? rev10(s) : s);
      h = {q_r[35:32], br[3] ? rev8(q_r[31:0]) : q_r[31:0]};
      cmp_data({4'h0, host_rx_c, host_rx_d}, {4'h0, h});
      h = {q_h[35:32], br[1] ? rev8(q_h[31:0]) : q_h[31:0]};
      h = (ls[1] & ~q14) ? q_r : h;
      cmp_data({4'h0, tx_path_c, tx_path_d}, {4'h0, h});
    end
    {q_a, q_b, q_e, q14} = {rxa_raw, rxb_raw, tx_enc, ctrl0_bit14};
    {q_r, q_h} = {rx_path_c, rx_path_d, host_tx_c, host_tx_d};
  end
  initial begin
    {core_clk, resetn, dchk, align_ok, deskew_collision} = '0;
    {all_lanes_sync, ctrl0_bit14, code_err, deskew_state} = '0;
    {lane_sync_state, rxa_raw, rxb_raw, tx_enc} = '0;
    {rx_path_c, rx_path_d, host_tx_c, host_tx_d} = '0;
    {failures, comparisons, cycles, br, ls} = '0;
    port_addr = 5'h1A;
    void'($urandom(72816));
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    // three errors on lane 3 push it from reset value to the top
    align_ok <= 1'b1;
    code_err <= 4'h8;
    repeat (3) @(posedge core_clk);
    code_err <= 4'h0;
    for (int n = 0; n < 4; n++) begin
      rdc(16'(TALLY0_ADDR + n), n == 3 ? TALLY_MAX : TALLY_RESET);
      rdc(16'(TALLY0_ADDR + n), 16'h0000);
    end
    $display("test reset and saturation done");
    // random errors, counted only while aligned
    repeat (60) begin
      ce = 4'($urandom());
      ao = 1'($urandom());
      for (int n = 0; n < 4; n++) tally[n] += ce[n] & ao;
      code_err <= ce;
      align_ok <= ao;
      @(posedge core_clk);
    end
    code_err <= 4'h0;
    for (int n = 0; n < 4; n++)
      rdc(16'(TALLY0_ADDR + n), 16'(tally[n]));
    $display("test random counting done");
    lane_sync_state <= 12'($urandom());
    deskew_state <= 4'($urandom());
    {all_lanes_sync, deskew_collision} <= 2'b11;
    @(posedge core_clk);
    deskew_collision <= 1'b0;
    rdc(SYNC_STATES_ADDR, {4'h0, lane_sync_state});
    rdc(DESKEW_ADDR, {deskew_state, 12'h001});
    rdc(DESKEW_ADDR, {deskew_state, 12'h000});
    for (int k = 0; k < 2; k++) begin
      rdc(ALL_SYNC_ADDR, 16'h0000);
      rdc(ALL_SYNC_ADDR, 16'h0800);
      all_lanes_sync <= 1'b0;
      @(posedge core_clk);
      all_lanes_sync <= 1'b1;
    end
    rdc(16'h8019, 16'h0000);
    acc(OP_READ, 5'h06, BITREV_ADDR, 16'h0000, rv);
    cmp_reg(rv, 16'hFFFF);
    rdc(BITREV_ADDR, BITREV_RESET);
    // read with post-increment steps on to the loopback register
    host_u.frame(OP_READ_INC, DEVAD_B, 16'h0000, rv);
    cmp_reg(rv, BITREV_RESET);
    host_u.frame(OP_READ, DEVAD_B, 16'h0000, rv);
    cmp_reg(rv, LOOPSEL_RESET);
    $display("test status and refusal done");
    for (int k = 0; k < 5; k++) begin
      {br, ls} = CFG[k][6:1];
      acc(OP_WRITE, DEVAD_B, BITREV_ADDR, {12'h000, br}, rv);
      acc(OP_WRITE, DEVAD_B, LOOPSEL_ADDR, {14'h0000, ls}, rv);
      ctrl0_bit14 <= CFG[k][0];
      @(posedge core_clk);
      dchk = 1'b1;
      repeat (20) @(negedge core_clk);
      dchk = 1'b0;
      rdc(LOOPSEL_ADDR, {14'h0000, ls});
    end
    $display("test data paths done");
    tally_and_finish();
  end
endmodule // rldr_regs_tb
